// ===== rtl/phy_clk_pkg.sv
// Shared constants, speed codes and pin carriers for the tri-speed PHY clocking adapter.
package phy_clk_pkg;

    // Reference rate of the transmit clock at gigabit speed, and of the local clock.
    localparam int REF_CLK_MHZ = 125;
    localparam int CLOCK_MHZ = 100;

    // Pad delay applied to the forwarded RGMII transmit clock.
    localparam int TXC_DELAY_NS = 2;

    // Width of the enable divider and the cycles per enable at 100 and 10 Mb/s.
    localparam int DIV_W = 7;
    localparam logic [DIV_W-1:0] DIV_100M = 7'h0A;
    localparam logic [DIV_W-1:0] DIV_10M = 7'h64;

    // Width of the user datapath, the MII nibble and the depth of the transmit buffer.
    localparam int BYTE_W = 8;
    localparam int NIBBLE_W = 4;
    localparam int TX_FIFO_DEPTH = 32;

    // Reset values of the registered pin groups.
    localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;

    typedef enum logic [1:0] {
        SPEED_10 = 2'b00,
        SPEED_100 = 2'b01,
        SPEED_1000 = 2'b10
    } speed_e;

    typedef enum logic {
        TX_IDLE = 1'b0,
        TX_HIGH = 1'b1
    } tx_state_e;

    typedef enum logic {
        RX_LOW = 1'b0,
        RX_HIGH = 1'b1
    } rx_state_e;

    // Inputs of both DDR output registers per pin, plus the forwarded clock's delay enable.
    typedef struct packed {
        logic clk_delay;
        logic clk_rise;
        logic clk_fall;
        logic ctl_rise;
        logic ctl_fall;
        logic [BYTE_W-1:0] d_rise;
        logic [BYTE_W-1:0] d_fall;
    } ddr_pins_s;

    // Receive pins and the PHY transmit clock, as one synchroniser group.
    typedef struct packed {
        logic rx_clk;
        logic rx_ctl;
        logic [BYTE_W-1:0] rx_d;
        logic mii_tx_clk;
    } pin_in_s;

endpackage

// ===== rtl/stream_fifo.sv
// Parameterised stream FIFO with a registered output stage.
module stream_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // Filling side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg, wr_ptr_next;
    logic [PTR_W-1:0] rd_ptr_reg, rd_ptr_next;
    logic [CNT_W-1:0] count_reg, count_next;
    logic out_valid_reg, out_valid_next;
    logic [WIDTH-1:0] out_data_reg, out_data_next;
    logic push;
    logic load;

    assign in_ready = (count_reg != CNT_W'(DEPTH));
    assign push = in_valid && in_ready;
    // The output stage refills from memory whenever it is empty or being drained.
    assign load = (count_reg != '0) && (!out_valid_reg || out_ready);
    assign out_valid = out_valid_reg;
    assign out_data = out_data_reg;

    always_comb begin
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        count_next = count_reg;
        out_valid_next = out_valid_reg;
        out_data_next = out_data_reg;
        if (push) begin
            wr_ptr_next = wr_ptr_reg + PTR_W'(1);
        end
        if (load) begin
            rd_ptr_next = rd_ptr_reg + PTR_W'(1);
            out_data_next = mem[rd_ptr_reg];
            out_valid_next = 1'b1;
        end else if (out_ready) begin
            out_valid_next = 1'b0;
        end
        count_next = count_reg + CNT_W'(push) - CNT_W'(load);
    end

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            out_valid_reg <= 1'b0;
            out_data_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg <= count_next;
            out_valid_reg <= out_valid_next;
            out_data_reg <= out_data_next;
        end
    end

endmodule

// ===== rtl/trispeed_phy_clocking_adapter.sv
// Tri-speed PHY clocking adapter: enable generation, DDR pin preparation and receive assembly.
//
// Overview of operation
// RULE1: Gigabit transmit pacing assumes the reference clock rate.
// RULE2: GMII transmit pacing follows PHY clock below gigabit.
// RULE3: Transmit enable delivered; stream handshake throttles nibbles.
// RULE4: Receive enable delivered; nibbles paired into bytes.
// RULE5: GMII gigabit forwarded clock is inverted DDR.
// RULE6: RGMII uses one clock at all speeds.
// RULE7: RGMII enable: always, one in ten, hundred.
// RULE8: User moves one item per qualified cycle; the transmit FIFO accepts a byte on any cycle it has room.
// RULE9: RGMII forwarded clock DDR, then delayed 2 ns.
// RULE10: Slow RGMII toggles clock DDR inputs at rate.
// RULE11: Receive pins sampled on the PHY clock.
// RULE12: RGMII carries nibbles on both clock edges.
// RULE13: Own receive clock; only RGMII shares transmit.
// RULE14: Enables evenly spaced, restart on speed change.
module trispeed_phy_clocking_adapter #(
    parameter bit IS_RGMII = 1'b1,
    parameter int FIFO_DEPTH = phy_clk_pkg::TX_FIFO_DEPTH
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // Operating speed.
    input wire phy_clk_pkg::speed_e speed,
    // Transmit user stream.
    input wire logic tx_tvalid,
    output logic tx_tready,
    input wire logic [phy_clk_pkg::BYTE_W-1:0] tx_tdata,
    // Receive user stream.
    output logic rx_tvalid,
    output logic [phy_clk_pkg::BYTE_W-1:0] rx_tdata,
    // Clock enables towards the MAC core level.
    output logic tx_enable,
    output logic rx_enable,
    // PHY pins, transmit side.
    input wire logic mii_tx_clk,
    output phy_clk_pkg::ddr_pins_s tx_pins,
    output logic tx_clk_shareable,
    // PHY pins, receive side.
    input wire logic rx_clk_pin,
    input wire logic rx_ctl_pin,
    input wire logic [phy_clk_pkg::BYTE_W-1:0] rx_d_pin
);
    localparam int DW = phy_clk_pkg::DIV_W;
    localparam int BW = phy_clk_pkg::BYTE_W;
    localparam int NW = phy_clk_pkg::NIBBLE_W;

    // Cycles of the local clock per enable at 100 and 10 Mb/s; gigabit returns the 10 Mb/s count.
    function automatic logic [DW-1:0] period_of(input phy_clk_pkg::speed_e s);
        logic [DW-1:0] p;
        p = phy_clk_pkg::DIV_10M;
        if (s == phy_clk_pkg::SPEED_100) begin
            p = phy_clk_pkg::DIV_100M;
        end
        return p;
    endfunction

    // Synchronisers: the first stage feeds only the second.
    phy_clk_pkg::pin_in_s sync1_reg, sync2_reg;
    logic rx_clk_prev_reg, mii_clk_prev_reg;
    phy_clk_pkg::speed_e speed_prev_reg;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            rx_clk_prev_reg <= 1'b0;
            mii_clk_prev_reg <= 1'b0;
            speed_prev_reg <= phy_clk_pkg::SPEED_10;
        end else begin
            sync1_reg <= {rx_clk_pin, rx_ctl_pin, rx_d_pin, mii_tx_clk};
            sync2_reg <= sync1_reg;
            rx_clk_prev_reg <= sync2_reg.rx_clk;
            mii_clk_prev_reg <= sync2_reg.mii_tx_clk;
            speed_prev_reg <= speed;
        end
    end

    logic changed;
    logic is_gig;
    logic rx_rise, rx_fall, mii_rise;
    logic [DW-1:0] div_period;
    logic [DW-1:0] div_max;
    logic [DW-1:0] div_half;

    assign changed = (speed != speed_prev_reg);
    assign is_gig = (speed == phy_clk_pkg::SPEED_1000);
    assign rx_rise = sync2_reg.rx_clk && !rx_clk_prev_reg;
    assign rx_fall = !sync2_reg.rx_clk && rx_clk_prev_reg;
    assign mii_rise = sync2_reg.mii_tx_clk && !mii_clk_prev_reg;
    assign div_period = period_of(speed);
    assign div_max = div_period - DW'(1);
    assign div_half = div_period >> 1;

    // Transmit enable generation and pin preparation.
    logic [DW-1:0] div_reg, div_next;
    phy_clk_pkg::tx_state_e tx_state_reg, tx_state_next;
    logic [BW-1:0] hold_reg, hold_next;
    phy_clk_pkg::ddr_pins_s pins_reg, pins_next;
    logic tx_tick;
    logic fifo_valid, fifo_ready;
    logic [BW-1:0] fifo_data;
    logic fifo_pop;

    // RGMII paces every speed from the one local clock; GMII takes the PHY clock below gigabit.
    always_comb begin
        if (IS_RGMII) begin
            tx_tick = !changed && (is_gig || div_reg == '0); // RULE6 RULE7 RULE14
        end else begin
            tx_tick = !changed && (is_gig || mii_rise); // RULE1 RULE2 RULE14
        end
    end

    assign tx_enable = tx_tick; // RULE3
    assign fifo_pop = fifo_valid && fifo_ready;
    assign tx_pins = pins_reg;
    assign tx_clk_shareable = IS_RGMII; // RULE13

    stream_fifo #(
        .WIDTH(BW),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .clock(clock),
        .rst_n(rst_n),
        .in_valid(tx_tvalid),
        .in_ready(tx_tready),
        .in_data(tx_tdata),
        .out_valid(fifo_valid),
        .out_ready(fifo_ready),
        .out_data(fifo_data)
    );

    always_comb begin
        div_next = div_reg;
        tx_state_next = tx_state_reg;
        hold_next = hold_reg;
        pins_next = pins_reg;
        fifo_ready = 1'b0;
        if (changed) begin
            div_next = '0; // RULE14
            tx_state_next = phy_clk_pkg::TX_IDLE;
        end else if (is_gig || div_reg >= div_max) begin
            div_next = '0;
        end else begin
            div_next = div_reg + DW'(1);
        end
        if (IS_RGMII) begin
            pins_next.clk_delay = 1'b1; // RULE9
            if (is_gig) begin
                pins_next.clk_rise = 1'b1; // RULE9
                pins_next.clk_fall = 1'b0;
            end else begin
                pins_next.clk_rise = (div_reg >= div_half); // RULE10
                pins_next.clk_fall = (div_reg >= div_half); // RULE10
            end
        end else begin
            pins_next.clk_delay = 1'b0;
            pins_next.clk_rise = 1'b0; // RULE5
            pins_next.clk_fall = is_gig; // RULE5
        end
        if (tx_tick) begin
            case (tx_state_reg)
                phy_clk_pkg::TX_IDLE: begin
                    fifo_ready = 1'b1; // RULE3
                    pins_next.ctl_rise = fifo_valid;
                    pins_next.ctl_fall = fifo_valid;
                    if (!fifo_valid) begin
                        pins_next.d_rise = phy_clk_pkg::BYTE_RESET;
                        pins_next.d_fall = phy_clk_pkg::BYTE_RESET;
                    end else if (is_gig && IS_RGMII) begin
                        pins_next.d_rise = {4'h0, fifo_data[NW-1:0]}; // RULE12
                        pins_next.d_fall = {4'h0, fifo_data[BW-1:NW]}; // RULE12
                    end else if (is_gig) begin
                        pins_next.d_rise = fifo_data;
                        pins_next.d_fall = fifo_data;
                    end else begin
                        pins_next.d_rise = {4'h0, fifo_data[NW-1:0]}; // RULE3
                        pins_next.d_fall = {4'h0, fifo_data[NW-1:0]};
                        hold_next = fifo_data;
                        tx_state_next = phy_clk_pkg::TX_HIGH;
                    end
                end
                phy_clk_pkg::TX_HIGH: begin
                    pins_next.d_rise = {4'h0, hold_reg[BW-1:NW]}; // RULE3
                    pins_next.d_fall = {4'h0, hold_reg[BW-1:NW]};
                    tx_state_next = phy_clk_pkg::TX_IDLE;
                end
                default: begin
                    tx_state_next = phy_clk_pkg::TX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= '0;
            tx_state_reg <= phy_clk_pkg::TX_IDLE;
            hold_reg <= phy_clk_pkg::BYTE_RESET;
            pins_reg <= '0;
        end else begin
            div_reg <= div_next;
            tx_state_reg <= tx_state_next;
            hold_reg <= hold_next;
            pins_reg <= pins_next;
        end
    end

    // Receive sampling on the PHY clock edges and byte assembly.
    phy_clk_pkg::rx_state_e rx_state_reg, rx_state_next;
    logic [NW-1:0] low_reg, low_next;
    logic dv_reg, dv_next;
    logic rx_valid_reg, rx_valid_next;
    logic [BW-1:0] rx_data_reg, rx_data_next;

    assign rx_enable = rx_rise && !changed; // RULE4 RULE11
    assign rx_tvalid = rx_valid_reg;
    assign rx_tdata = rx_data_reg;

    always_comb begin
        rx_state_next = rx_state_reg;
        low_next = low_reg;
        dv_next = dv_reg;
        rx_valid_next = 1'b0;
        rx_data_next = rx_data_reg;
        if (changed) begin
            rx_state_next = phy_clk_pkg::RX_LOW;
            dv_next = 1'b0;
        end else if (is_gig && IS_RGMII) begin
            if (rx_rise) begin
                low_next = sync2_reg.rx_d[NW-1:0]; // RULE11 RULE12
                dv_next = sync2_reg.rx_ctl;
            end else if (rx_fall && dv_reg) begin
                rx_data_next = {sync2_reg.rx_d[NW-1:0], low_reg}; // RULE12
                rx_valid_next = 1'b1;
            end
        end else if (is_gig) begin
            if (rx_rise && sync2_reg.rx_ctl) begin
                rx_data_next = sync2_reg.rx_d; // RULE11
                rx_valid_next = 1'b1;
            end
        end else if (rx_rise) begin
            if (!sync2_reg.rx_ctl) begin
                rx_state_next = phy_clk_pkg::RX_LOW;
            end else begin
                case (rx_state_reg)
                    phy_clk_pkg::RX_LOW: begin
                        low_next = sync2_reg.rx_d[NW-1:0]; // RULE4
                        rx_state_next = phy_clk_pkg::RX_HIGH;
                    end
                    phy_clk_pkg::RX_HIGH: begin
                        rx_data_next = {sync2_reg.rx_d[NW-1:0], low_reg}; // RULE4
                        rx_valid_next = 1'b1;
                        rx_state_next = phy_clk_pkg::RX_LOW;
                    end
                    default: begin
                        rx_state_next = phy_clk_pkg::RX_LOW;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_state_reg <= phy_clk_pkg::RX_LOW;
            low_reg <= '0;
            dv_reg <= 1'b0;
            rx_valid_reg <= 1'b0;
            rx_data_reg <= phy_clk_pkg::BYTE_RESET;
        end else begin
            rx_state_reg <= rx_state_next;
            low_reg <= low_next;
            dv_reg <= dv_next;
            rx_valid_reg <= rx_valid_next;
            rx_data_reg <= rx_data_next;
        end
    end

    // Gap counter between transmit enables, read only by the checks below.
    logic [DW-1:0] gap_reg;
    logic gap_seen_reg;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            gap_reg <= '0;
            gap_seen_reg <= 1'b0;
        end else if (changed) begin
            gap_reg <= '0;
            gap_seen_reg <= 1'b0;
        end else if (tx_enable) begin
            gap_reg <= '0;
            gap_seen_reg <= 1'b1;
        end else begin
            gap_reg <= gap_reg + DW'(1);
        end
    end

    chk_gig_enable_high: assert property ( // RULE7
        @(posedge clock) disable iff (!rst_n)
        (IS_RGMII && is_gig && !changed) |-> tx_enable)
        else $error("gigabit transmit enable not held high");

    chk_enable_period: assert property ( // RULE7
        @(posedge clock) disable iff (!rst_n)
        (IS_RGMII && tx_enable && gap_seen_reg && !is_gig) |-> (gap_reg == div_max))
        else $error("transmit enable spacing wrong for speed");

    chk_change_restart: assert property ( // RULE14
        @(posedge clock) disable iff (!rst_n)
        (IS_RGMII && changed && speed != phy_clk_pkg::SPEED_1000) |-> !tx_enable ##1 tx_enable)
        else $error("enable did not restart cleanly after speed change");

    chk_pop_on_enable: assert property ( // RULE3
        @(posedge clock) disable iff (!rst_n)
        fifo_pop |-> (tx_enable && tx_state_reg == phy_clk_pkg::TX_IDLE))
        else $error("transmit byte taken outside a qualified cycle");

    chk_pins_hold: assert property ( // RULE3
        @(posedge clock) disable iff (!rst_n)
        !tx_enable |=> ($stable(tx_pins.d_rise) && $stable(tx_pins.ctl_rise)))
        else $error("transmit data pins changed without enable");

    chk_gmii_inverted: assert property ( // RULE5
        @(posedge clock) disable iff (!rst_n)
        (!IS_RGMII && is_gig) |=> (tx_pins.clk_fall && !tx_pins.clk_rise))
        else $error("gigabit GMII forwarded clock not inverted");

    chk_rgmii_clk_gig: assert property ( // RULE9
        @(posedge clock) disable iff (!rst_n)
        (IS_RGMII && is_gig) |=> (tx_pins.clk_rise && !tx_pins.clk_fall && tx_pins.clk_delay))
        else $error("RGMII forwarded clock not DDR with delay");

    chk_slow_clk_toggle: assert property ( // RULE10
        @(posedge clock) disable iff (!rst_n)
        (IS_RGMII && !is_gig && !changed && (div_reg == '0 || div_reg == div_half)) |=>
            ((tx_pins.clk_rise == tx_pins.clk_fall) &&
            (tx_pins.clk_rise == $past(div_reg == div_half))))
        else $error("slow RGMII forwarded clock phase wrong");

    chk_ddr_nibbles: assert property ( // RULE12
        @(posedge clock) disable iff (!rst_n)
        (IS_RGMII && is_gig && fifo_pop) |=> (tx_pins.d_fall[NW-1:0] == $past(fifo_data[BW-1:NW])))
        else $error("RGMII high nibble not on falling edge");

    chk_rx_edge_source: assert property ( // RULE11
        @(posedge clock) disable iff (!rst_n)
        rx_tvalid |-> $past(rx_rise || rx_fall))
        else $error("receive byte without a PHY clock edge");

endmodule

// ===== verification/phy_model.sv
// External PHY model: receive clock, control and nibble data, plus a free-running transmit clock.
module phy_model (
    // Receive pins driven towards the adapter.
    output logic rx_clk,
    output logic rx_ctl,
    output logic [7:0] rx_d,
    // Transmit clock sourced by the PHY.
    output logic mii_tx_clk
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        rx_clk = 1'b0;
        rx_ctl = 1'b0;
        rx_d = 8'hA5;
        mii_tx_clk = 1'b0;
    end

    // The PHY transmit clock runs free and has no phase relation to the local clock.
    always #20 mii_tx_clk = ~mii_tx_clk;

    // One 160 ns receive clock period; data is set up 40 ns before each edge and held 40 ns after.
    task automatic rx_cycle(input logic [3:0] nib_r, input logic [3:0] nib_f);
        rx_ctl = 1'b1;
        rx_d = {~nib_r, nib_r};
        #40;
        rx_clk = 1'b1;
        #40;
        rx_d = {~nib_f, nib_f};
        #40;
        rx_clk = 1'b0;
        #40;
    endtask

    // Sends a frame, byte per period on both edges or low nibble then high nibble per period.
    task automatic rx_frame(input logic [7:0] bytes[$], input logic ddr);
        foreach (bytes[i]) begin
            if (ddr) begin
                rx_cycle(bytes[i][3:0], bytes[i][7:4]);
            end else begin
                rx_cycle(bytes[i][3:0], bytes[i][3:0]);
                rx_cycle(bytes[i][7:4], bytes[i][7:4]);
            end
        end
        // The clock stands still between frames and the idle data lines no longer hold the last value.
        rx_ctl = 1'b0;
        rx_d = ~rx_d;
    endtask
endmodule

// ===== verification/trispeed_phy_clocking_adapter_test.sv
// Self-checking bench for the tri-speed PHY clocking adapter with an RGMII PHY model.
module trispeed_phy_clocking_adapter_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock;
    logic rst_n;
    phy_clk_pkg::speed_e speed;
    logic tx_tvalid;
    logic tx_tready;
    logic [7:0] tx_tdata;
    logic rx_tvalid;
    logic [7:0] rx_tdata;
    logic tx_enable;
    logic rx_enable;
    logic mii_tx_clk;
    phy_clk_pkg::ddr_pins_s tx_pins;
    logic tx_clk_shareable;
    logic rx_clk_pin;
    logic rx_ctl_pin;
    logic [7:0] rx_d_pin;
    logic [7:0] exp_tx[$];
    logic [7:0] got_tx[$];
    logic [7:0] exp_rx[$];
    logic [7:0] got_rx[$];
    logic [7:0] frame[$];
    logic [3:0] low_nib;
    logic half;
    logic en_prev;
    int error_cnt;
    int checks_done;
    int seed;
    int acc;
    int rx_edges;

    trispeed_phy_clocking_adapter trispeed_phy_clocking_adapter_inst (
        .clock(clock), .rst_n(rst_n), .speed(speed),
        .tx_tvalid(tx_tvalid), .tx_tready(tx_tready), .tx_tdata(tx_tdata),
        .rx_tvalid(rx_tvalid), .rx_tdata(rx_tdata),
        .tx_enable(tx_enable), .rx_enable(rx_enable),
        .mii_tx_clk(mii_tx_clk), .tx_pins(tx_pins), .tx_clk_shareable(tx_clk_shareable),
        .rx_clk_pin(rx_clk_pin), .rx_ctl_pin(rx_ctl_pin), .rx_d_pin(rx_d_pin)
    );

    phy_model phy_model_inst (
        .rx_clk(rx_clk_pin), .rx_ctl(rx_ctl_pin), .rx_d(rx_d_pin), .mii_tx_clk(mii_tx_clk)
    );

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Collects transmit items from the pins in the cycle after each qualified cycle.
    always @(negedge clock) begin
        if (en_prev === 1'b1 && tx_pins.ctl_rise === 1'b1) begin
            if (speed == phy_clk_pkg::SPEED_1000) begin
                got_tx.push_back({tx_pins.d_fall[3:0], tx_pins.d_rise[3:0]});
            end else if (half) begin
                got_tx.push_back({tx_pins.d_rise[3:0], low_nib});
                half = 1'b0;
            end else begin
                low_nib = tx_pins.d_rise[3:0];
                half = 1'b1;
            end
        end else if (en_prev === 1'b1) begin
            half = 1'b0;
        end
        en_prev = tx_enable;
        if (rx_tvalid === 1'b1) got_rx.push_back(rx_tdata);
        if (rx_enable === 1'b1) rx_edges++;
    end

    task automatic test_done;
        $display("Checks made %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        cmp_byte({7'h00, got}, {7'h00, exp});
    endtask

    task automatic cmp_num(input int got, input int exp);
        checks_done++;
        if (got != exp) begin
            error_cnt++;
            $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // Offers one byte and holds it until the adapter takes it.
    task automatic send(input logic [7:0] b);
        int n;
        tx_tvalid <= 1'b1;
        tx_tdata <= b;
        for (n = 0; n < 3000; n++) begin
            @(negedge clock);
            if (tx_tready === 1'b1) break;
        end
        if (n == 3000) begin
            error_cnt++;
            test_done();
        end
        @(posedge clock);
        exp_tx.push_back(b);
    endtask

    // Changes speed, then measures the enable spacing and the forwarded clock's high time.
    task automatic check_pace(input phy_clk_pkg::speed_e s, input int p);
        int gap;
        int hi;
        speed <= s;
        @(negedge clock);
        cmp_bit(tx_enable, 1'b0);
        @(negedge clock);
        cmp_bit(tx_enable, 1'b1);
        repeat (3) begin
            gap = 0;
            hi = 0;
            do begin
                @(negedge clock);
                gap++;
                if (tx_pins.clk_rise === 1'b1) hi++;
                cmp_bit(tx_pins.clk_fall, p > 1 ? tx_pins.clk_rise : 1'b0);
            end while (tx_enable !== 1'b1 && gap < 200);
            cmp_num(gap, p);
            cmp_num(hi, p > 1 ? p / 2 : p);
        end
        @(posedge clock);
    endtask

    // Waits for both directions to empty, then compares the collected items in order.
    task automatic drain(input int edges);
        int n;
        for (n = 0; n < 20000; n++) begin
            @(posedge clock);
            if (got_tx.size() == exp_tx.size() && got_rx.size() == exp_rx.size()) break;
        end
        if (n == 20000) begin
            error_cnt++;
            test_done();
        end
        repeat (300) @(posedge clock);
        cmp_num(got_tx.size(), exp_tx.size());
        cmp_num(got_rx.size(), exp_rx.size());
        while (exp_tx.size() > 0 && got_tx.size() > 0) cmp_byte(got_tx.pop_front(), exp_tx.pop_front());
        while (exp_rx.size() > 0 && got_rx.size() > 0) cmp_byte(got_rx.pop_front(), exp_rx.pop_front());
        if (edges > 0) cmp_num(rx_edges, edges);
    endtask

    // Sends random bytes both ways at the current speed, with boundary values on receive and their 5A-masked forms on transmit.
    task automatic run_traffic(input int n, input logic ddr);
        frame = {8'h00, 8'hFF};
        repeat (n) frame.push_back(8'($random(seed)));
        foreach (frame[i]) exp_rx.push_back(frame[i]);
        rx_edges = 0;
        fork
            begin
                foreach (frame[i]) send(frame[i] ^ 8'h5A);
                tx_tvalid <= 1'b0;
            end
            phy_model_inst.rx_frame(frame, ddr);
        join
        drain(ddr ? 0 : 2 * frame.size());
    endtask

    initial begin
        seed = 25;
        error_cnt = 0;
        checks_done = 0;
        rst_n = 1'b0;
        speed = phy_clk_pkg::SPEED_10;
        tx_tvalid = 1'b0;
        tx_tdata = 8'h00;
        half = 1'b0;
        en_prev = 1'b0;
        rx_edges = 0;
        repeat (10) @(posedge clock);
        cmp_bit(tx_tready, 1'b1);
        cmp_bit(|tx_pins, 1'b0);
        cmp_bit(tx_clk_shareable, 1'b1);
        rst_n <= 1'b1;
        repeat (4) @(posedge clock);
        check_pace(phy_clk_pkg::SPEED_100, 10);
        check_pace(phy_clk_pkg::SPEED_10, 100);
        check_pace(phy_clk_pkg::SPEED_1000, 1);
        cmp_bit(tx_pins.clk_delay, 1'b1);
        run_traffic(8, 1'b1);
        speed <= phy_clk_pkg::SPEED_100;
        repeat (3) @(posedge clock);
        run_traffic(4, 1'b0);
        speed <= phy_clk_pkg::SPEED_10;
        repeat (3) @(posedge clock);
        acc = 0;
        tx_tvalid <= 1'b1;
        tx_tdata <= 8'($random(seed));
        for (int i = 0; i < 40; i++) begin
            @(negedge clock);
            if (tx_tready !== 1'b1) break;
            @(posedge clock);
            exp_tx.push_back(tx_tdata);
            acc++;
            tx_tdata <= 8'($random(seed));
        end
        @(posedge clock);
        tx_tvalid <= 1'b0;
        cmp_num(acc, phy_clk_pkg::TX_FIFO_DEPTH + 1);
        drain(0);
        test_done();
    end
endmodule
